// ===== hdl/command_write_protection.sv
// per-command write protection and security level tracking
`timescale 1ns/1ps
module command_write_protection
    import write_protect_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_start_i,
    input wire logic [7:0] wr_code_i,
    input wire logic wr_byte_valid_i,
    input wire logic [7:0] wr_byte_i,
    input wire logic wr_stop_i,
    input wire logic rd_start_i,
    input wire logic [7:0] rd_code_i,
    input wire logic [71:0] default_private_i,
    input wire logic [71:0] user_private_i,
    input wire logic [31:0] user_public_i,
    output logic wr_accept_o,
    output logic wr_reject_o,
    output logic [7:0] wr_accept_code_o,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic [1:0] access_level_o,
    output logic [255:0] default_mask_o,
    output logic [255:0] user_mask_o
);

    write_state_type state, next_state;
    logic [7:0] code, next_code;
    logic [7:0] block_len, next_block_len;
    logic [5:0] byte_count, next_byte_count;
    logic [7:0] data_buf [0:buf_bytes-1];
    logic [7:0] next_data_buf [0:buf_bytes-1];
    logic [1:0] access_level, next_access_level;
    logic [255:0] default_mask, next_default_mask;
    logic [255:0] user_mask, next_user_mask;
    logic next_wr_accept, next_wr_reject;
    logic [7:0] next_wr_accept_code;
    logic next_rd_valid;
    logic [7:0] next_rd_data;
    logic [255:0] flat_buf;
    logic [1:0] required_level;
    logic block_ok;

    // bytes arrive least significant first, so byte 0 lands in bits 7:0
    always_comb
    begin
        for (int i = 0; i < buf_bytes; i++)
        begin
            flat_buf[i*8 +: 8] = data_buf[i];
        end
    end

    // level a write to the held command code needs
    always_comb
    begin
        if (code == private_password_code || code == public_password_code)
        begin
            required_level = level_none;
        end
        else if (code == write_mask_code)
        begin
            required_level = level_user;
        end
        else if (!default_mask[code])
        begin
            required_level = level_vendor;
        end
        else if (!user_mask[code])
        begin
            required_level = level_user;
        end
        else
        begin
            required_level = level_public;
        end
    end

    // count byte plus exactly that many data bytes, count matching the command
    always_comb
    begin
        block_ok = 1'b0;
        if (code == private_password_code)
        begin
            block_ok = (block_len == private_password_len);
        end
        else if (code == public_password_code)
        begin
            block_ok = (block_len == public_password_len);
        end
        else if (code == write_mask_code)
        begin
            block_ok = (block_len == write_mask_len);
        end
        block_ok = block_ok && ({2'h0, byte_count} == block_len + 8'h01);
    end

    always_comb
    begin
        next_state = state;
        next_code = code;
        next_block_len = block_len;
        next_byte_count = byte_count;
        next_data_buf = data_buf;
        next_access_level = access_level;
        next_default_mask = default_mask;
        next_user_mask = user_mask;
        next_wr_accept = 1'b0;
        next_wr_reject = 1'b0;
        next_wr_accept_code = wr_accept_code_o;
        // reads are served whatever the masks say
        next_rd_valid = rd_start_i;
        next_rd_data = 8'h00;
        if (rd_start_i && rd_code_i == access_level_code)
        begin
            next_rd_data = {6'h00, access_level};
        end
        unique case (state)
            idle_st:
            begin
                if (wr_start_i)
                begin
                    next_state = collect_st;
                    next_code = wr_code_i;
                    next_byte_count = 6'h00;
                    next_block_len = 8'h00;
                end
            end
            collect_st:
            begin
                if (wr_stop_i)
                begin
                    next_state = idle_st;
                    if (code == public_password_code)
                    begin
                        if (block_ok)
                        begin
                            next_wr_accept = 1'b1;
                            // the default store public copy plays no part
                            if (flat_buf[public_bits-1:0] == user_public_i)
                            begin
                                next_access_level = level_public;
                            end
                            else
                            begin
                                next_access_level = level_none;
                            end
                        end
                        else
                        begin
                            next_wr_reject = 1'b1;
                        end
                    end
                    else if (code == private_password_code)
                    begin
                        if (block_ok)
                        begin
                            next_wr_accept = 1'b1;
                            if (flat_buf[private_bits-1:0] == default_private_i)
                            begin
                                next_access_level = level_vendor;
                            end
                            else if (flat_buf[private_bits-1:0] == user_private_i &&
                                     access_level < level_user)
                            begin
                                next_access_level = level_user;
                            end
                        end
                        else
                        begin
                            next_wr_reject = 1'b1;
                        end
                    end
                    else if (code == access_level_code)
                    begin
                        next_wr_reject = 1'b1;
                    end
                    else if (code == write_mask_code)
                    begin
                        // vendor level edits the default copy, user level the user copy
                        if (block_ok && access_level == level_vendor)
                        begin
                            next_wr_accept = 1'b1;
                            next_default_mask = flat_buf;
                        end
                        else if (block_ok && access_level == level_user)
                        begin
                            next_wr_accept = 1'b1;
                            next_user_mask = flat_buf;
                        end
                        else
                        begin
                            next_wr_reject = 1'b1;
                        end
                    end
                    else if (access_level >= required_level && byte_count != 6'h00)
                    begin
                        next_wr_accept = 1'b1;
                    end
                    else
                    begin
                        next_wr_reject = 1'b1;
                    end
                    next_wr_accept_code = code;
                end
                else if (wr_start_i)
                begin
                    // repeated start drops the unfinished write
                    next_code = wr_code_i;
                    next_byte_count = 6'h00;
                    next_block_len = 8'h00;
                end
                else if (wr_byte_valid_i)
                begin
                    if (byte_count == 6'h00)
                    begin
                        next_block_len = wr_byte_i;
                    end
                    else if (byte_count <= 6'(buf_bytes))
                    begin
                        next_data_buf[5'(byte_count - 6'h01)] = wr_byte_i;
                    end
                    // saturating keeps an overlong block from wrapping into a valid count
                    if (byte_count != byte_count_max)
                    begin
                        next_byte_count = byte_count + 6'h01;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state <= idle_st;
            code <= 8'h00;
            block_len <= 8'h00;
            byte_count <= 6'h00;
            for (int i = 0; i < buf_bytes; i++)
            begin
                data_buf[i] <= 8'h00;
            end
            access_level <= access_level_reset;
            default_mask <= write_mask_reset;
            user_mask <= write_mask_reset;
            wr_accept_o <= 1'b0;
            wr_reject_o <= 1'b0;
            wr_accept_code_o <= 8'h00;
            rd_valid_o <= 1'b0;
            rd_data_o <= 8'h00;
            access_level_o <= access_level_reset;
            default_mask_o <= write_mask_reset;
            user_mask_o <= write_mask_reset;
        end
        else
        begin
            state <= next_state;
            code <= next_code;
            block_len <= next_block_len;
            byte_count <= next_byte_count;
            data_buf <= next_data_buf;
            access_level <= next_access_level;
            default_mask <= next_default_mask;
            user_mask <= next_user_mask;
            wr_accept_o <= next_wr_accept;
            wr_reject_o <= next_wr_reject;
            wr_accept_code_o <= next_wr_accept_code;
            rd_valid_o <= next_rd_valid;
            rd_data_o <= next_rd_data;
            access_level_o <= next_access_level;
            default_mask_o <= next_default_mask;
            user_mask_o <= next_user_mask;
        end
    end

endmodule

// ===== hdl/write_protect_pkg.sv
// constants for the command write protection block
package write_protect_pkg;

    // command codes
    localparam logic [7:0] access_level_code = 8'hfa;
    localparam logic [7:0] private_password_code = 8'hfb;
    localparam logic [7:0] public_password_code = 8'hfc;
    localparam logic [7:0] write_mask_code = 8'hfd;

    // block data lengths in bytes, count byte excluded
    localparam logic [7:0] private_password_len = 8'h09;
    localparam logic [7:0] public_password_len = 8'h04;
    localparam logic [7:0] write_mask_len = 8'h20;

    // widths
    localparam int mask_bits = 256;
    localparam int private_bits = 72;
    localparam int public_bits = 32;
    localparam int buf_bytes = 32;

    // security levels
    localparam logic [1:0] level_none = 2'h0;
    localparam logic [1:0] level_public = 2'h1;
    localparam logic [1:0] level_user = 2'h2;
    localparam logic [1:0] level_vendor = 2'h3;

    // reset values
    localparam logic [1:0] access_level_reset = 2'h1;
    localparam logic [255:0] write_mask_reset = {256{1'b1}};

    // received byte counter saturates here
    localparam logic [5:0] byte_count_max = 6'h3f;

    typedef enum logic [0:0] {idle_st, collect_st} write_state_type;

endpackage

// ===== tb/command_write_protection_tb.sv
// self-checking bench for the command write protection block
`timescale 1ns/1ps
`define CHK(a, b) \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
        n_errors++; \
        $display("BAD %0t mismatch", $time); \
    end
module command_write_protection_tb;
    import write_protect_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_start_i, wr_byte_valid_i, wr_stop_i, rd_start_i;
    logic [7:0] wr_code_i, wr_byte_i, rd_code_i, rd_data_o, wr_accept_code_o;
    logic wr_accept_o, wr_reject_o, rd_valid_o;
    logic [1:0] access_level_o;
    logic [255:0] default_mask_o, user_mask_o, m;
    logic [71:0] default_private_i = 72'h0123456789abcdef42;
    logic [71:0] user_private_i = 72'h55aa3c1e0f9876aa01;
    logic [31:0] user_public_i = 32'h3e5b7a19;
    int n_errors = 0;
    int cmp_count = 0;
    always #2 clock_i = ~clock_i;
    command_write_protection dut (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_start_i(wr_start_i),
        .wr_code_i(wr_code_i),
        .wr_byte_valid_i(wr_byte_valid_i),
        .wr_byte_i(wr_byte_i),
        .wr_stop_i(wr_stop_i),
        .rd_start_i(rd_start_i),
        .rd_code_i(rd_code_i),
        .default_private_i(default_private_i),
        .user_private_i(user_private_i),
        .user_public_i(user_public_i),
        .wr_accept_o(wr_accept_o),
        .wr_reject_o(wr_reject_o),
        .wr_accept_code_o(wr_accept_code_o),
        .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o),
        .access_level_o(access_level_o),
        .default_mask_o(default_mask_o),
        .user_mask_o(user_mask_o)
    );
    host_model u_host (.clock_i(clock_i), .wr_start_o(wr_start_i), .wr_code_o(wr_code_i),
        .wr_byte_valid_o(wr_byte_valid_i), .wr_byte_o(wr_byte_i), .wr_stop_o(wr_stop_i),
        .rd_start_o(rd_start_i), .rd_code_o(rd_code_i));
    task automatic wr(input logic [7:0] c, input int n, input logic [263:0] d,
        input logic a, input logic [1:0] l);
        u_host.write(c, n, d);
        `CHK(wr_accept_o, a)
        `CHK(wr_reject_o, !a)
        `CHK(access_level_o, l)
        `CHK(wr_accept_code_o, c)
        u_host.read(access_level_code);
        `CHK(rd_valid_o, 1'b1)
        `CHK(rd_data_o, {6'h00, l})
    endtask
    task automatic pub(input logic ok);
        wr(8'hfc, 5, {ok ? user_public_i : ~user_public_i, 8'h04}, 1, {1'b0, ok});
    endtask
    task automatic priv(input logic [71:0] p, input logic [1:0] l);
        wr(8'hfb, 10, {p, 8'h09}, 1, l);
    endtask
    task automatic t_reset();
        u_host.read(access_level_code);
        `CHK(rd_valid_o, 1'b1)
        `CHK(rd_data_o, 8'h01)
        `CHK(default_mask_o, write_mask_reset)
        u_host.read(8'h21);
        `CHK(rd_valid_o, 1'b1)
        `CHK(rd_data_o, 8'h00)
        wr(access_level_code, 1, 264'h02, 0, 2'h1);
    endtask
    task automatic t_public();
        pub(0);
        wr(8'h21, 1, 264'h5a, 0, 2'h0);
        pub(1);
        wr(8'h21, 1, 264'h5a, 1, 2'h1);
    endtask
    task automatic t_private();
        priv(~user_private_i, 2'h1);
        priv(user_private_i, 2'h2);
        pub(0);
        priv(default_private_i, 2'h3);
        priv(user_private_i, 2'h3);
        pub(1);
    endtask
    task automatic t_mask();
        m = write_mask_reset;
        m[8'h21] = 1'b0;
        m[0] = 1'b0;
        wr(8'hfd, 33, {m, 8'h20}, 0, 2'h1);
        priv(default_private_i, 2'h3);
        wr(8'hfd, 33, {m, 8'h20}, 1, 2'h3);
        `CHK(default_mask_o, m)
        `CHK(user_mask_o, write_mask_reset)
        u_host.read(8'h00);
        `CHK(rd_valid_o, 1'b1)
        `CHK(rd_data_o, 8'h00)
        wr(8'h00, 1, 264'h11, 1, 2'h3);
        pub(1);
        wr(8'h00, 1, 264'h11, 0, 2'h1);
        priv(user_private_i, 2'h2);
        wr(8'h21, 1, 264'h11, 0, 2'h2);
        m = write_mask_reset;
        m[8'h30] = 1'b0;
        wr(8'hfd, 33, {m, 8'h20}, 1, 2'h2);
        `CHK(user_mask_o, m)
        wr(8'h30, 1, 264'h11, 1, 2'h2);
        pub(1);
        wr(8'h30, 1, 264'h11, 0, 2'h1);
    endtask
    task automatic t_malformed();
        wr(8'hfc, 4, {user_public_i[23:0], 8'h04}, 0, 2'h1);
        wr(8'hfc, 5, {~user_public_i, 8'h05}, 0, 2'h1);
        wr(8'hfb, 11, {8'h00, default_private_i, 8'h09}, 0, 2'h1);
        wr(8'h22, 0, 264'h00, 0, 2'h1);
    endtask
    task automatic final_report();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_errors++;
        final_report();
    end
    initial
    begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_public();
        t_private();
        t_mask();
        t_malformed();
        final_report();
    end
endmodule
bind command_write_protection cwp_sva u_sva (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .wr_start_i(wr_start_i),
    .wr_stop_i(wr_stop_i),
    .rd_start_i(rd_start_i),
    .rd_code_i(rd_code_i),
    .wr_accept_o(wr_accept_o),
    .wr_reject_o(wr_reject_o),
    .wr_accept_code_o(wr_accept_code_o),
    .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o),
    .access_level_o(access_level_o),
    .default_mask_o(default_mask_o),
    .user_mask_o(user_mask_o)
);

// ===== tb/cwp_sva.sv
// port assertions for the command write protection block
`timescale 1ns/1ps
module cwp_sva
    import write_protect_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_start_i,
    input wire logic wr_stop_i,
    input wire logic rd_start_i,
    input wire logic [7:0] rd_code_i,
    input wire logic wr_accept_o,
    input wire logic wr_reject_o,
    input wire logic [7:0] wr_accept_code_o,
    input wire logic rd_valid_o,
    input wire logic [7:0] rd_data_o,
    input wire logic [1:0] access_level_o,
    input wire logic [255:0] default_mask_o,
    input wire logic [255:0] user_mask_o
);
    // a stop outside a transaction must not count as a decision
    logic open;
    logic next_open;
    logic done;
    // mirrors the design: a stop only closes an open write, and a start while idle opens one
    assign next_open = !rst_i && (open ? !wr_stop_i : wr_start_i);
    assign done = open && wr_stop_i;
    always_ff @(posedge clock_i)
        open <= next_open;
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    property p_answer; done |=> wr_accept_o != wr_reject_o; endproperty
    a_answer: assert property (p_answer) else $error("no single answer");
    property p_read; rd_start_i |=> rd_valid_o; endproperty
    a_read: assert property (p_read) else $error("read not served");
    property p_rd_lvl; rd_start_i && rd_code_i == access_level_code
        |=> rd_data_o == {6'h00, $past(access_level_o)}; endproperty
    a_rd_lvl: assert property (p_rd_lvl) else $error("level read wrong");
    property p_hold; !done |=> !wr_accept_o && !wr_reject_o && $stable(access_level_o)
        && $stable(default_mask_o) && $stable(user_mask_o); endproperty
    a_hold: assert property (p_hold) else $error("state moved without decision");
    property p_priv; wr_accept_o && wr_accept_code_o == private_password_code
        |-> access_level_o >= $past(access_level_o); endproperty
    a_priv: assert property (p_priv) else $error("private lowered level");
    property p_pub; wr_accept_o && wr_accept_code_o == public_password_code
        |-> access_level_o <= level_public; endproperty
    a_pub: assert property (p_pub) else $error("public left level high");
    property p_lvl_ro; wr_accept_o && wr_accept_code_o == access_level_code |-> 0; endproperty
    a_lvl_ro: assert property (p_lvl_ro) else $error("level write accepted");
    property p_mask; wr_accept_o && wr_accept_code_o == write_mask_code
        |-> $past(access_level_o) >= level_user; endproperty
    a_mask: assert property (p_mask) else $error("mask written too low");
    property p_rej; wr_reject_o |-> $stable(access_level_o) && $stable(default_mask_o)
        && $stable(user_mask_o); endproperty
    a_rej: assert property (p_rej) else $error("reject changed state");
endmodule

// ===== tb/host_model.sv
// management bus host model issuing command writes and reads
`timescale 1ns/1ps
module host_model (
    input wire logic clock_i,
    output logic wr_start_o = 1'b0,
    output logic [7:0] wr_code_o = 8'h00,
    output logic wr_byte_valid_o = 1'b0,
    output logic [7:0] wr_byte_o = 8'h00,
    output logic wr_stop_o = 1'b0,
    output logic rd_start_o = 1'b0,
    output logic [7:0] rd_code_o = 8'h00
);
    // n bytes from d, lowest first; idle lines are inverted so stale data never looks valid
    task automatic write(input logic [7:0] c, input int n, input logic [263:0] d);
        @(posedge clock_i);
        wr_start_o <= 1'b1;
        wr_code_o <= c;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clock_i);
            wr_start_o <= 1'b0;
            wr_code_o <= ~c;
            wr_byte_valid_o <= 1'b1;
            wr_byte_o <= d[8*i +: 8];
        end
        @(posedge clock_i);
        wr_start_o <= 1'b0;
        wr_byte_valid_o <= 1'b0;
        wr_byte_o <= ~wr_byte_o;
        wr_stop_o <= 1'b1;
        @(posedge clock_i);
        wr_stop_o <= 1'b0;
        #1;
    endtask
    task automatic read(input logic [7:0] c);
        @(posedge clock_i);
        rd_start_o <= 1'b1;
        rd_code_o <= c;
        @(posedge clock_i);
        rd_start_o <= 1'b0;
        rd_code_o <= ~c;
        #1;
    endtask
endmodule
